// *** hw/exec_pkg.sv ***
// constants and types shared by the transfer and table-lookup executor
`default_nettype none
package exec_pkg;
  localparam int INSTR_W = 10;
  localparam int NIB_W = 4;
  localparam int PAGE_W = 6;
  localparam int DREG_W = 3;
  localparam int UPPER_W = 2;
  localparam int ROM_ADDR_W = 1 + PAGE_W + DREG_W + NIB_W;
  // opcode field positions
  localparam int OP6_HI = 9;
  localparam int OP6_LO = 4;
  localparam int OP4_HI = 9;
  localparam int OP4_LO = 6;
  // table word field positions
  localparam int ROW_UP_HI = 9;
  localparam int ROW_UP_LO = 8;
  localparam int ROW_B_HI = 7;
  localparam int ROW_B_LO = 4;
  localparam int ROW_A_HI = 3;
  localparam int ROW_A_LO = 0;
  // opcodes, upper six bits
  localparam logic [5:0] OPC_MEM_TO_ACC = 6'h2C;
  localparam logic [5:0] OPC_EXCHANGE = 6'h2D;
  localparam logic [5:0] OPC_EXCH_INC = 6'h2E;
  localparam logic [5:0] OPC_EXCH_DEC = 6'h2F;
  localparam logic [5:0] OPC_ACC_TO_MEM = 6'h2B;
  localparam logic [5:0] OPC_LOAD_ACC = 6'h07;
  // table reference, upper four bits
  localparam logic [3:0] OPC_TABLE_REF = 4'h2;
  // reset values, step size, wrap points and bank codes
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;
  localparam logic [3:0] Y_WRAP_DEC = 4'hF;
  localparam logic [3:0] Y_WRAP_INC = 4'h0;
  localparam logic [1:0] UPPER_RST = 2'h0;
  localparam logic BANK_LOW = 1'b0;
  localparam logic BANK_HIGH = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_LOAD = 3'b100
  } tab_state_type;

  typedef enum logic [6:0] {
    CMD_NONE = 7'b0000001,
    CMD_MEM_TO_ACC = 7'b0000010,
    CMD_EXCHANGE = 7'b0000100,
    CMD_EXCH_DEC = 7'b0001000,
    CMD_EXCH_INC = 7'b0010000,
    CMD_ACC_TO_MEM = 7'b0100000,
    CMD_LOAD_ACC = 7'b1000000
  } cmd_type;
endpackage
`default_nettype wire

// *** hw/y_step_unit.sv ***
// register y step with wrap detection for the exchange variants
`timescale 1ns/1ns
`default_nettype none
module y_step_unit
  import exec_pkg::*;
(
  input wire logic [exec_pkg::NIB_W-1:0] y_in,
  input wire logic dec_en,
  input wire logic inc_en,
  output logic [exec_pkg::NIB_W-1:0] y_out,
  output logic wrap
);
  import exec_pkg::*;

  always_comb begin
    y_out = y_in;
    wrap = 1'b0;
    if (dec_en) begin
      y_out = y_in - NIB_ONE;
      wrap = (y_out == Y_WRAP_DEC);
    end else if (inc_en) begin
      y_out = y_in + NIB_ONE;
      wrap = (y_out == Y_WRAP_INC);
    end
  end
endmodule // y_step_unit
`default_nettype wire

// *** hw/ram_transfer_table_lookup_exec.sv ***
// executor for ram transfer, exchange, immediate load and table lookup
`timescale 1ns/1ns
`default_nettype none
module ram_transfer_table_lookup_exec
  import exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [exec_pkg::INSTR_W-1:0] instr,
  output logic instr_ready,
  input wire logic [exec_pkg::NIB_W-1:0] ram_rdata,
  output logic ram_we,
  output logic [exec_pkg::NIB_W-1:0] ram_wdata,
  input wire logic [exec_pkg::DREG_W-1:0] d_reg,
  input wire logic select_high_bank,
  input wire logic select_low_bank,
  input wire logic backup_return,
  output logic rom_rd,
  output logic [exec_pkg::ROM_ADDR_W-1:0] rom_addr_q,
  input wire logic [exec_pkg::INSTR_W-1:0] rom_rdata,
  output logic stack_push,
  output logic stack_pop,
  output logic [exec_pkg::NIB_W-1:0] acc_q,
  output logic [exec_pkg::NIB_W-1:0] x_q,
  output logic [exec_pkg::NIB_W-1:0] y_q,
  output logic [exec_pkg::NIB_W-1:0] b_q,
  output logic [exec_pkg::UPPER_W-1:0] table_upper_bits_reg_q,
  output logic bank_q,
  output logic skip_q
);
  import exec_pkg::*;

  function automatic cmd_type decode(input logic [INSTR_W-1:0] w);
    cmd_type c;
    c = CMD_NONE;
    unique case (w[OP6_HI:OP6_LO])
      OPC_MEM_TO_ACC: c = CMD_MEM_TO_ACC;
      OPC_EXCHANGE: c = CMD_EXCHANGE;
      OPC_EXCH_DEC: c = CMD_EXCH_DEC;
      OPC_EXCH_INC: c = CMD_EXCH_INC;
      OPC_ACC_TO_MEM: c = CMD_ACC_TO_MEM;
      OPC_LOAD_ACC: c = CMD_LOAD_ACC;
      default: c = CMD_NONE;
    endcase
    return c;
  endfunction

  tab_state_type state_q;
  cmd_type cmd;
  logic take;
  logic exec;
  logic is_table;
  logic is_load;
  logic la_skip;
  logic prev_load_q;
  logic x_group;
  logic exch_group;
  logic [NIB_W-1:0] imm4;
  logic [PAGE_W-1:0] page;
  logic [NIB_W-1:0] y_next;
  logic y_wrap;

  assign cmd = decode(instr);
  assign imm4 = instr[NIB_W-1:0];
  assign page = instr[PAGE_W-1:0];
  assign is_table = (instr[OP4_HI:OP4_LO] == OPC_TABLE_REF);
  assign is_load = (cmd == CMD_LOAD_ACC);
  assign instr_ready = (state_q == ST_IDLE);
  assign take = instr_valid && instr_ready;
  // a load right after a load is passed over, even if the first was skipped
  assign la_skip = is_load && prev_load_q;
  assign exec = take && !skip_q && !la_skip;
  assign exch_group = (cmd == CMD_EXCHANGE) || (cmd == CMD_EXCH_DEC) ||
                      (cmd == CMD_EXCH_INC);
  assign x_group = exch_group || (cmd == CMD_MEM_TO_ACC) ||
                   (cmd == CMD_ACC_TO_MEM);

  // y steps only when the exchange really executes; wrap arms the skip
  y_step_unit y_step_unit_inst (
    .y_in(y_q),
    .dec_en(cmd == CMD_EXCH_DEC),
    .inc_en(cmd == CMD_EXCH_INC),
    .y_out(y_next),
    .wrap(y_wrap)
  );

  // ram sees old acc while acc takes old ram in the same cycle
  assign ram_we = exec && (exch_group || cmd == CMD_ACC_TO_MEM);
  assign ram_wdata = acc_q;
  assign stack_push = exec && is_table;
  assign stack_pop = (state_q == ST_LOAD);
  assign rom_rd = (state_q == ST_READ);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (exec && is_table) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: state_q <= ST_LOAD;
        ST_LOAD: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_load_q <= 1'b0;
    end else if (take) begin
      prev_load_q <= is_load;
    end
  end

  // a skip is consumed by the next instruction taken, whatever it is
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= 1'b0;
    end else if (take) begin
      skip_q <= exec && y_wrap;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= NIB_RST;
    end else if (state_q == ST_LOAD) begin
      acc_q <= rom_rdata[ROW_A_HI:ROW_A_LO];
    end else if (exec && (cmd == CMD_MEM_TO_ACC || exch_group)) begin
      acc_q <= ram_rdata;
    end else if (exec && is_load) begin
      acc_q <= imm4;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q <= NIB_RST;
    end else if (exec && x_group) begin
      x_q <= x_q ^ imm4;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      y_q <= NIB_RST;
    end else if (exec && (cmd == CMD_EXCH_DEC || cmd == CMD_EXCH_INC)) begin
      y_q <= y_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= NIB_RST;
      table_upper_bits_reg_q <= UPPER_RST;
    end else if (state_q == ST_LOAD) begin
      b_q <= rom_rdata[ROW_B_HI:ROW_B_LO];
      table_upper_bits_reg_q <= rom_rdata[ROW_UP_HI:ROW_UP_LO];
    end
  end

  // low bank wins a tie so a wakeup never lands in the high pages
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= BANK_LOW;
    end else if (select_low_bank || backup_return) begin
      bank_q <= BANK_LOW;
    end else if (select_high_bank) begin
      bank_q <= BANK_HIGH;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_addr_q <= '0;
    end else if (exec && is_table) begin
      rom_addr_q <= {bank_q, page, d_reg, acc_q};
    end
  end

  sequence s_table_start;
    exec && is_table;
  endsequence

  sequence s_table_body;
    rom_rd && !instr_ready ##1 stack_pop && !instr_ready;
  endsequence

  a_mem_copy: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && cmd == CMD_MEM_TO_ACC |-> !ram_we ##1
      acc_q == $past(ram_rdata))
    else $error("acc did not take ram nibble");

  a_x_xor_update: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && x_group |=> x_q == ($past(x_q) ^ $past(imm4)))
    else $error("x not xored with immediate");

  a_exchange_swap: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && exch_group |-> ram_we && ram_wdata == acc_q ##1
      acc_q == $past(ram_rdata))
    else $error("exchange did not swap");

  a_dec_wrap_skip: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && cmd == CMD_EXCH_DEC |=> y_q == 4'($past(y_q) - NIB_ONE) &&
      skip_q == ($past(y_q) == NIB_RST))
    else $error("decrement or its skip wrong");

  a_inc_wrap_skip: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && cmd == CMD_EXCH_INC |=> y_q == 4'($past(y_q) + NIB_ONE) &&
      skip_q == ($past(y_q) == Y_WRAP_DEC))
    else $error("increment or its skip wrong");

  a_store_keep: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && cmd == CMD_ACC_TO_MEM |-> ram_we && ram_wdata == acc_q ##1
      acc_q == $past(acc_q))
    else $error("store changed acc or missed write");

  a_load_imm: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exec && is_load |=> acc_q == $past(imm4))
    else $error("immediate not loaded");

  a_load_chain: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    take && is_load ##1 take && is_load |-> !exec)
    else $error("repeated load executed");

  // an idle gap between loads still counts as consecutive
  a_chain_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    take && la_skip |=> $stable(acc_q))
    else $error("repeated load changed acc");

  a_table_split: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_table_start |=> s_table_body ##1
      b_q == $past(rom_rdata[ROW_B_HI:ROW_B_LO]) &&
      acc_q == $past(rom_rdata[ROW_A_HI:ROW_A_LO]) &&
      table_upper_bits_reg_q == $past(rom_rdata[ROW_UP_HI:ROW_UP_LO]))
    else $error("table word not split");

  a_table_addr: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_table_start |=> rom_addr_q ==
      {$past(bank_q), $past(page), $past(d_reg), $past(acc_q)})
    else $error("table address wrong");

  // the fetch stalls the stream so the stack level is freed before reuse
  a_table_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    stack_push |=> !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("table reference length wrong");

  a_push_pop: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    stack_push |-> !stack_pop ##2 stack_pop)
    else $error("stack level not released");

  a_bank_select: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    select_high_bank && !select_low_bank && !backup_return |=>
      bank_q == BANK_HIGH)
    else $error("high bank not selected");

  a_bank_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    select_low_bank || backup_return |=> bank_q == BANK_LOW)
    else $error("low bank not selected");

  a_skip_suppress: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    take && skip_q |-> !exec && !ram_we ##1 !skip_q)
    else $error("skipped instruction had effect");

  a_skip_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    take && skip_q |=> $stable(acc_q) && $stable(x_q) && $stable(y_q))
    else $error("skipped instruction changed a register");
endmodule // ram_transfer_table_lookup_exec
`default_nettype wire

// *** testbench/mem_model.sv ***
// data ram and table rom model facing the executor
`timescale 1ns/1ns
`default_nettype none
module mem_model
  import exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [exec_pkg::NIB_W-1:0] x,
  input wire logic [exec_pkg::NIB_W-1:0] y,
  input wire logic we,
  input wire logic [exec_pkg::NIB_W-1:0] wdata,
  output logic [exec_pkg::NIB_W-1:0] rdata,
  input wire logic rd,
  input wire logic [exec_pkg::ROM_ADDR_W-1:0] addr,
  output logic [exec_pkg::INSTR_W-1:0] word
);
  import exec_pkg::*;
  logic [NIB_W-1:0] mem [256];
  // word stays unknown until the first read, so an early sample shows up
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 4'(i >> 4) ^ ~4'(i);
  end
  assign rdata = mem[{x, y}];
  always @(posedge ref_clk) begin
    if (we) mem[{x, y}] <= wdata;
    // one cycle of latency; between reads the word is scrambled
    word <= rd ? (addr[9:0] ^ {addr[13:10], 6'h2A}) : ~word;
  end
endmodule // mem_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the transfer and table executor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import exec_pkg::*;
  logic ref_clk, rst_n, instr_valid, instr_ready, ram_we, rom_rd, bank_q;
  logic select_high_bank, select_low_bank, backup_return, skip_q;
  logic stack_push, stack_pop;
  logic [INSTR_W-1:0] instr, rom_rdata;
  logic [NIB_W-1:0] ram_rdata, ram_wdata, acc_q, x_q, y_q, b_q;
  logic [DREG_W-1:0] d_reg;
  logic [ROM_ADDR_W-1:0] rom_addr_q;
  logic [UPPER_W-1:0] table_upper_bits_reg_q;
  int fails, cmp_count;

  ram_transfer_table_lookup_exec ram_transfer_table_lookup_exec_inst (
    .ref_clk, .rst_n, .instr_valid, .instr, .instr_ready, .ram_rdata,
    .ram_we, .ram_wdata, .d_reg, .select_high_bank, .select_low_bank,
    .backup_return, .rom_rd, .rom_addr_q, .rom_rdata, .stack_push,
    .stack_pop, .acc_q, .x_q, .y_q, .b_q, .table_upper_bits_reg_q,
    .bank_q, .skip_q);
  mem_model mem_model_inst (.ref_clk(ref_clk), .x(x_q), .y(y_q),
    .we(ram_we), .wdata(ram_wdata), .rdata(ram_rdata), .rd(rom_rd),
    .addr(rom_addr_q), .word(rom_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic exe(logic [9:0] v);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = v;
  endtask

  task automatic idle;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask

  function automatic logic [3:0] m(logic [3:0] x, logic [3:0] y);
    return mem_model_inst.mem[{x, y}];
  endfunction

  task automatic t_transfer;
    logic [3:0] a, v;
    v = m(4'h0, 4'h0);
    exe({OPC_MEM_TO_ACC, 4'h3});
    idle;
    check("acc copy", acc_q, v);
    check("ram kept", m(4'h0, 4'h0), v);
    check("x xor", x_q, 4'h3);
    a = acc_q;
    v = m(4'h3, 4'h0);
    exe({OPC_EXCHANGE, 4'h5});
    idle;
    check("xchg acc", acc_q, v);
    check("xchg ram", m(4'h3, 4'h0), a);
    check("xchg x", x_q, 4'h6);
    a = acc_q;
    exe({OPC_ACC_TO_MEM, 4'h1});
    idle;
    check("store ram", m(4'h6, 4'h0), a);
    check("store acc", acc_q, a);
    check("store x", x_q, 4'h7);
  endtask

  task automatic t_skip;
    logic [3:0] v, a;
    v = m(4'h7, 4'h0);
    exe({OPC_EXCH_DEC, 4'h0});
    exe({OPC_LOAD_ACC, 4'hA});
    check("dec skip", skip_q, 1'b1);
    idle;
    check("dec y", y_q, 4'hF);
    check("skipped load", acc_q, v);
    check("skip clear", skip_q, 1'b0);
    a = acc_q;
    v = m(4'h7, 4'hF);
    exe({OPC_EXCH_INC, 4'h0});
    exe({OPC_EXCHANGE, 4'h2});
    idle;
    check("inc y", y_q, 4'h0);
    check("inc acc", acc_q, v);
    check("inc ram", m(4'h7, 4'hF), a);
    check("skipped x", x_q, 4'h7);
    exe({OPC_EXCH_INC, 4'h0});
    exe({OPC_LOAD_ACC, 4'h3});
    exe({OPC_ACC_TO_MEM, 4'h0});
    idle;
    check("no wrap y", y_q, 4'h1);
    check("no wrap load", acc_q, 4'h3);
  endtask

  task automatic t_loads;
    exe({OPC_LOAD_ACC, 4'h5});
    exe({OPC_LOAD_ACC, 4'hA});
    exe({OPC_LOAD_ACC, 4'hC});
    idle;
    check("first load", acc_q, 4'h5);
    exe({OPC_ACC_TO_MEM, 4'h0});
    exe({OPC_LOAD_ACC, 4'h9});
    idle;
    check("fresh load", acc_q, 4'h9);
  endtask

  task automatic t_table(logic [5:0] p, logic bk);
    logic [13:0] a;
    logic [9:0] w;
    d_reg = p[2:0] ^ 3'h6;
    a = {bk, p, d_reg, acc_q};
    w = a[9:0] ^ {a[13:10], 6'h2A};
    exe({OPC_TABLE_REF, p});
    #1 check("push", stack_push, 1'b1);
    idle;
    check("rom addr", rom_addr_q, a);
    check("busy", instr_ready, 1'b0);
    @(negedge ref_clk);
    check("pop", stack_pop, 1'b1);
    @(negedge ref_clk);
    check("upper", table_upper_bits_reg_q, w[9:8]);
    check("b", b_q, w[7:4]);
    check("acc tab", acc_q, w[3:0]);
  endtask

  task automatic bank(logic h, logic l, logic b);
    @(negedge ref_clk);
    select_high_bank = h;
    select_low_bank = l;
    backup_return = b;
    @(negedge ref_clk);
    select_high_bank = 1'b0;
    select_low_bank = 1'b0;
    backup_return = 1'b0;
  endtask

  task automatic t_banks;
    check("bank rst", bank_q, BANK_LOW);
    t_table(6'h2A, 1'b0);
    bank(1'b1, 1'b0, 1'b0);
    check("bank hi", bank_q, BANK_HIGH);
    t_table(6'h15, 1'b1);
    bank(1'b0, 1'b1, 1'b0);
    t_table(6'h3F, 1'b0);
    bank(1'b1, 1'b0, 1'b0);
    bank(1'b0, 1'b0, 1'b1);
    check("bank backup", bank_q, BANK_LOW);
    bank(1'b1, 1'b0, 1'b0);
    bank(1'b1, 1'b1, 1'b0);
    check("bank tie", bank_q, BANK_LOW);
    bank(1'b1, 1'b0, 1'b0);
    check("bank hi again", bank_q, BANK_HIGH);
    @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    check("bank after reset", bank_q, BANK_LOW);
    check("acc after reset", acc_q, NIB_RST);
  endtask

  // watchdog so a stalled run still reaches the verdict
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    conclude;
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 10'h000;
    d_reg = 3'h0;
    select_high_bank = 1'b0;
    select_low_bank = 1'b0;
    backup_return = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    t_transfer;
    t_skip;
    t_loads;
    t_banks;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
